/* rtl/fpu_decode_regs.svh */
// opcode, field and latency constants for the store and transcendental decoder
`ifndef FPU_DECODE_REGS_SVH
`define FPU_DECODE_REGS_SVH

// ----------------------------------------
// opcode bytes and operand-byte fields
// ----------------------------------------
`define OPC_D9 8'hD9
`define OPC_DB 8'hDB
`define OPC_DD 8'hDD
`define OPC_DF 8'hDF
`define MODRM_MOD_RANGE 7:6
`define MODRM_REG_RANGE 5:3
`define MODRM_RM_RANGE 2:0
`define MODRM_HI_RANGE 7:3
`define MOD_REGISTER 2'b11
`define FLD_000 3'h0
`define FLD_010 3'h2
`define FLD_011 3'h3
`define FLD_100 3'h4
`define FLD_110 3'h6
`define FLD_111 3'h7
`define STORE_REG_HI 5'h1A
`define SUB_ATAN 8'hF3
`define SUB_PREM 8'hF8
`define SUB_PREM1 8'hF5
`define SUB_TAN 8'hF2
`define SUB_RND 8'hFC
`define SUB_SCALE 8'hFD
`define SUB_SIN 8'hFE
`define SUB_SINCOS 8'hFB
`define SUB_SQRT 8'hFA
`define SUB_STATUS_ACC 8'hE0

// ----------------------------------------
// latencies in core clocks
// ----------------------------------------
`define LAT_W 8
`define LAT_ATAN_MIN 8'd97
`define LAT_ATAN_MAX 8'd161
`define LAT_PREM_MIN 8'd82
`define LAT_PREM_MAX 8'd91
`define LAT_TAN_MIN 8'd117
`define LAT_TAN_MAX 8'd129
`define LAT_RND_MIN 8'd10
`define LAT_RND_MAX 8'd20
`define LAT_RESTORE_MIN 8'd56
`define LAT_RESTORE_MAX 8'd72
`define LAT_WSAVE_MIN 8'd57
`define LAT_WSAVE_MAX 8'd67
`define LAT_NSAVE_MIN 8'd55
`define LAT_NSAVE_MAX 8'd65
`define LAT_SCALE_MIN 8'd7
`define LAT_SCALE_MAX 8'd14
`define LAT_SIN_MIN 8'd76
`define LAT_SIN_MAX 8'd140
`define LAT_SINCOS_MIN 8'd145
`define LAT_SINCOS_MAX 8'd161
`define LAT_SQRT_MIN 8'd59
`define LAT_SQRT_MAX 8'd60
`define LAT_STORE_REAL 8'd2
`define LAT_BCD_MIN 8'd57
`define LAT_BCD_MAX 8'd63
`define LAT_INT32_MIN 8'd8
`define LAT_INT32_MAX 8'd13
`define LAT_INT16_MIN 8'd7
`define LAT_INT16_MAX 8'd10
`define LAT_INT64_MIN 8'd10
`define LAT_INT64_MAX 8'd13
`define LAT_WCTRL 8'd5
`define LAT_NCTRL 8'd3
`define LAT_WENV_MIN 8'd14
`define LAT_WENV_MAX 8'd24
`define LAT_NENV_MIN 8'd12
`define LAT_NENV_MAX 8'd22
`define LAT_WSTAT 8'd6
`define LAT_NSTAT 8'd4
`define LAT_WSTAT_ACC 8'd4
`define LAT_NSTAT_ACC 8'd2
`define LAT_ARG_REDUCE 8'd90

// ----------------------------------------
// stack pointer
// ----------------------------------------
`define TOP_W 3
`define TOP_RESET 3'h0
`define TOP_STEP 3'h1

`endif

/* rtl/fpu_decode_pkg.sv */
// types shared by the decoder and its testbench
package fpu_decode_pkg;

  typedef enum logic [4:0] {
    op_none, op_partial_arctangent, op_partial_remainder, op_ieee_partial_remainder,
    op_partial_tangent, op_round_to_integral, op_restore_unit_state, op_save_unit_state,
    op_power_of_two_scale, op_sine_eval, op_sine_cosine_eval, op_square_root_eval,
    op_store_real_entry, op_store_real_double, op_store_real_single, op_store_real_pop_ext,
    op_store_real_pop_double, op_store_real_pop_single, op_store_bcd_pop, op_store_integer_long,
    op_store_integer_word, op_store_integer_pop_quad, op_store_integer_pop_long,
    op_store_integer_pop_word, op_store_control_word, op_store_environment,
    op_store_status_word, op_store_status_accumulator
  } op_kind_t;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_wait = 3'b010,
    st_exec = 3'b100
  } seq_state_t;

endpackage

/* rtl/latency_timer.sv */
// down-counter that holds busy for a loaded number of clocks
`timescale 1ns/1ps
module latency_timer #(
  parameter int CNT_W = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [CNT_W-1:0] load_cnt,
  output logic busy,
  output logic done
);
  logic [CNT_W-1:0] cnt_q;
  logic last;

  assign last = (cnt_q == CNT_W'(1));

  // busy for load_cnt clocks, done one clock after
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= busy & last;
      if (start) begin
        cnt_q <= load_cnt;
        busy <= 1'b1;
      end else if (busy) begin
        cnt_q <= cnt_q - CNT_W'(1);
        busy <= ~last;
      end
    end
  end
endmodule

/* rtl/stack_pointer.sv */
// top-of-stack pointer with pop, push and reload
`timescale 1ns/1ps
`include "fpu_decode_regs.svh"
module stack_pointer (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic apply,
  input wire logic pop,
  input wire logic push,
  input wire logic reload,
  input wire logic [`TOP_W-1:0] reload_val,
  output logic [`TOP_W-1:0] top_ptr
);
  logic [`TOP_W-1:0] top_d;

  // pop counts up, push counts down, both cancel
  assign top_d = reload ? reload_val :
                 (pop & ~push) ? top_ptr + `TOP_STEP :
                 (push & ~pop) ? top_ptr - `TOP_STEP : top_ptr;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      top_ptr <= `TOP_RESET;
    end else if (clk_en && apply) begin
      top_ptr <= top_d;
    end
  end
endmodule

/* rtl/fpu_transcendental_store_decode.sv */
// decoder and latency sequencer for transcendental, state and store operations
//
// Contract
// - arctangent of entry one over top, pop, 97-161
// - partial remainder of top, 82-91 clocks
// - ieee remainder of top, 82-91 clocks
// - tangent of top then push one, 117-129
// - round top to integral, 10-20 clocks
// - restore full state from memory, 56-72
// - waiting save waits idle, 57-67 clocks
// - non-waiting save, no wait, 55-65 clocks
// - scale top by power of two, 7-14
// - sine of top, 76-140 clocks
// - sine replaces top, cosine pushed, 145-161
// - square root of top, 59-60 clocks
// - store real without pop, two clocks
// - store real then pop, two clocks
// - bcd store then pop, 57-63 clocks
// - integer store: long 8-13, word 7-10
// - integer store with pop, quad 10-13
// - control word store: waiting 5, else 3
// - environment store: waiting 14-24, else 12-22
// - status store: waiting 6, else 4
// - status to accumulator: waiting 4, else 2
// - pop increments pointer, push decrements it
// - large trig argument adds 90 clocks
// - small arctangent ratio finishes in 97
`timescale 1ns/1ps
`include "fpu_decode_regs.svh"
module fpu_transcendental_store_decode
  import fpu_decode_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [7:0] opcode_byte,
  input wire logic [7:0] modrm_byte,
  input wire logic wait_prefix,
  input wire logic ext_busy,
  input wire logic fast_case,
  input wire logic arg_out_of_range,
  input wire logic atan_small_ratio,
  input wire logic [`TOP_W-1:0] restore_top,
  output logic instr_taken,
  output logic illegal_op,
  output logic busy,
  output logic op_done,
  output fpu_decode_pkg::op_kind_t op_kind,
  output logic [2:0] dest_entry,
  output logic [`TOP_W-1:0] top_ptr
);
  import fpu_decode_pkg::*;

  // ----------------------------------------
  // operand byte fields
  // ----------------------------------------
  logic mem_form;
  logic [2:0] reg_fld;
  logic is_d9, is_db, is_dd, is_df;
  op_kind_t op_dec;

  assign mem_form = (modrm_byte[`MODRM_MOD_RANGE] != `MOD_REGISTER);
  assign reg_fld = modrm_byte[`MODRM_REG_RANGE];
  assign is_d9 = (opcode_byte == `OPC_D9);
  assign is_db = (opcode_byte == `OPC_DB);
  assign is_dd = (opcode_byte == `OPC_DD);
  assign is_df = (opcode_byte == `OPC_DF);

  // ----------------------------------------
  // opcode decode
  // ----------------------------------------
  // register forms of D9, DD and DF first, then memory forms per opcode byte
  assign op_dec =
    (is_d9 && modrm_byte == `SUB_ATAN) ? op_partial_arctangent :
    (is_d9 && modrm_byte == `SUB_PREM) ? op_partial_remainder :
    (is_d9 && modrm_byte == `SUB_PREM1) ? op_ieee_partial_remainder :
    (is_d9 && modrm_byte == `SUB_TAN) ? op_partial_tangent :
    (is_d9 && modrm_byte == `SUB_RND) ? op_round_to_integral :
    (is_d9 && modrm_byte == `SUB_SCALE) ? op_power_of_two_scale :
    (is_d9 && modrm_byte == `SUB_SIN) ? op_sine_eval :
    (is_d9 && modrm_byte == `SUB_SINCOS) ? op_sine_cosine_eval :
    (is_d9 && modrm_byte == `SUB_SQRT) ? op_square_root_eval :
    (is_dd && modrm_byte[`MODRM_HI_RANGE] == `STORE_REG_HI) ? op_store_real_entry :
    (is_df && modrm_byte == `SUB_STATUS_ACC) ? op_store_status_accumulator :
    !mem_form ? op_none :
    (is_dd && reg_fld == `FLD_100) ? op_restore_unit_state :
    (is_dd && reg_fld == `FLD_110) ? op_save_unit_state :
    (is_dd && reg_fld == `FLD_010) ? op_store_real_double :
    (is_d9 && reg_fld == `FLD_010) ? op_store_real_single :
    (is_db && reg_fld == `FLD_111) ? op_store_real_pop_ext :
    (is_dd && reg_fld == `FLD_011) ? op_store_real_pop_double :
    (is_d9 && reg_fld == `FLD_011) ? op_store_real_pop_single :
    (is_df && reg_fld == `FLD_110) ? op_store_bcd_pop :
    (is_db && reg_fld == `FLD_010) ? op_store_integer_long :
    (is_df && reg_fld == `FLD_010) ? op_store_integer_word :
    (is_df && reg_fld == `FLD_111) ? op_store_integer_pop_quad :
    (is_db && reg_fld == `FLD_011) ? op_store_integer_pop_long :
    (is_df && reg_fld == `FLD_011) ? op_store_integer_pop_word :
    (is_d9 && reg_fld == `FLD_111) ? op_store_control_word :
    (is_d9 && reg_fld == `FLD_110) ? op_store_environment :
    (is_dd && reg_fld == `FLD_111) ? op_store_status_word :
    op_none;

  // ----------------------------------------
  // latency selection
  // ----------------------------------------
  // fast picks the low figure (small ratio does for arctangent); large trig arguments add reduction time
  function automatic logic [`LAT_W-1:0] pick(input logic f, input logic [`LAT_W-1:0] lo,
                                             input logic [`LAT_W-1:0] hi);
    pick = f ? lo : hi;
  endfunction

  logic [`LAT_W-1:0] lat_base, lat_sel, reduce_add;
  logic trig_op;

  assign trig_op = (op_dec == op_partial_tangent) || (op_dec == op_sine_eval) ||
                   (op_dec == op_sine_cosine_eval);
  assign reduce_add = (trig_op && arg_out_of_range) ? `LAT_ARG_REDUCE : '0;
  assign lat_sel = lat_base + reduce_add;

  always_comb begin
    case (op_dec)
      op_partial_arctangent: lat_base = pick(atan_small_ratio, `LAT_ATAN_MIN, `LAT_ATAN_MAX);
      op_partial_remainder: lat_base = pick(fast_case, `LAT_PREM_MIN, `LAT_PREM_MAX);
      op_ieee_partial_remainder: lat_base = pick(fast_case, `LAT_PREM_MIN, `LAT_PREM_MAX);
      op_partial_tangent: lat_base = pick(fast_case, `LAT_TAN_MIN, `LAT_TAN_MAX);
      op_round_to_integral: lat_base = pick(fast_case, `LAT_RND_MIN, `LAT_RND_MAX);
      op_restore_unit_state: lat_base = pick(fast_case, `LAT_RESTORE_MIN, `LAT_RESTORE_MAX);
      op_save_unit_state: lat_base = wait_prefix ? pick(fast_case, `LAT_WSAVE_MIN, `LAT_WSAVE_MAX)
                                                 : pick(fast_case, `LAT_NSAVE_MIN, `LAT_NSAVE_MAX);
      op_power_of_two_scale: lat_base = pick(fast_case, `LAT_SCALE_MIN, `LAT_SCALE_MAX);
      op_sine_eval: lat_base = pick(fast_case, `LAT_SIN_MIN, `LAT_SIN_MAX);
      op_sine_cosine_eval: lat_base = pick(fast_case, `LAT_SINCOS_MIN, `LAT_SINCOS_MAX);
      op_square_root_eval: lat_base = pick(fast_case, `LAT_SQRT_MIN, `LAT_SQRT_MAX);
      op_store_bcd_pop: lat_base = pick(fast_case, `LAT_BCD_MIN, `LAT_BCD_MAX);
      op_store_integer_long, op_store_integer_pop_long:
        lat_base = pick(fast_case, `LAT_INT32_MIN, `LAT_INT32_MAX);
      op_store_integer_word, op_store_integer_pop_word:
        lat_base = pick(fast_case, `LAT_INT16_MIN, `LAT_INT16_MAX);
      op_store_integer_pop_quad: lat_base = pick(fast_case, `LAT_INT64_MIN, `LAT_INT64_MAX);
      op_store_control_word: lat_base = wait_prefix ? `LAT_WCTRL : `LAT_NCTRL;
      op_store_environment: lat_base = wait_prefix ? pick(fast_case, `LAT_WENV_MIN, `LAT_WENV_MAX)
                                                   : pick(fast_case, `LAT_NENV_MIN, `LAT_NENV_MAX);
      op_store_status_word: lat_base = wait_prefix ? `LAT_WSTAT : `LAT_NSTAT;
      op_store_status_accumulator: lat_base = wait_prefix ? `LAT_WSTAT_ACC : `LAT_NSTAT_ACC;
      default: lat_base = `LAT_STORE_REAL;
    endcase
  end

  // ----------------------------------------
  // stack effect of the held operation
  // ----------------------------------------
  logic op_pops, op_pushes, op_reloads;

  assign op_pops = (op_kind == op_partial_arctangent) || (op_kind == op_store_real_pop_ext) ||
                   (op_kind == op_store_real_pop_double) || (op_kind == op_store_real_pop_single) ||
                   (op_kind == op_store_bcd_pop) || (op_kind == op_store_integer_pop_quad) ||
                   (op_kind == op_store_integer_pop_long) || (op_kind == op_store_integer_pop_word);
  assign op_pushes = (op_kind == op_partial_tangent) || (op_kind == op_sine_cosine_eval);
  assign op_reloads = (op_kind == op_restore_unit_state);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  seq_state_t state_q, state_d;
  logic take, start, stall, tmr_busy, tmr_done;
  logic wait_q, reduce_q;
  logic [`LAT_W-1:0] lat_q;

  assign take = (state_q == st_idle) && instr_valid && (op_dec != op_none);
  assign stall = wait_prefix && ext_busy;
  assign start = (take && !stall) || ((state_q == st_wait) && !ext_busy);

  always_comb begin
    case (state_q)
      st_idle: state_d = take ? (stall ? st_wait : st_exec) : st_idle;
      st_wait: state_d = ext_busy ? st_wait : st_exec;
      st_exec: state_d = tmr_done ? st_idle : st_exec;
      default: state_d = st_idle;
    endcase
  end

  // state, held operation and one-cycle strobes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= st_idle;
      busy <= 1'b0;
      instr_taken <= 1'b0;
      illegal_op <= 1'b0;
      op_kind <= op_none;
      dest_entry <= '0;
      wait_q <= 1'b0;
      reduce_q <= 1'b0;
      lat_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      busy <= (state_d != st_idle);
      instr_taken <= take;
      illegal_op <= (state_q == st_idle) && instr_valid && (op_dec == op_none);
      if (take) begin
        op_kind <= op_dec;
        dest_entry <= modrm_byte[`MODRM_RM_RANGE];
        wait_q <= wait_prefix;
        reduce_q <= trig_op && arg_out_of_range;
        lat_q <= lat_sel;
      end
    end
  end

  latency_timer #(.CNT_W(`LAT_W)) u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(start),
    .load_cnt(take ? lat_sel : lat_q),
    .busy(tmr_busy),
    .done(op_done)
  );
  assign tmr_done = op_done;

  // stack moves when the operation retires
  stack_pointer u_stack (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .apply(tmr_done),
    .pop(op_pops),
    .push(op_pushes),
    .reload(op_reloads),
    .reload_val(restore_top),
    .top_ptr(top_ptr)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [`LAT_W-1:0] run_cnt_q;

  // clocks spent counting for the current operation
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_cnt_q <= '0;
    end else if (clk_en) begin
      run_cnt_q <= start ? '0 : (tmr_busy ? run_cnt_q + `LAT_W'(1) : run_cnt_q);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst || !clk_en);

  sequence s_retire(op_kind_t k);
    op_done && op_kind == k;
  endsequence

  sequence s_take_nowait;
    take && !stall;
  endsequence

  atan_window_a: assert property (s_retire(op_partial_arctangent) |->
    run_cnt_q >= `LAT_ATAN_MIN && run_cnt_q <= `LAT_ATAN_MAX)
    else $error("arctangent latency out of range");
  atan_small_a: assert property (take && op_dec == op_partial_arctangent && atan_small_ratio |-> ##[97:98] op_done)
    else $error("small-ratio arctangent not done in 97");
  sqrt_window_a: assert property (s_retire(op_square_root_eval) |->
    run_cnt_q == `LAT_SQRT_MIN || run_cnt_q == `LAT_SQRT_MAX)
    else $error("square root latency wrong");
  trig_reduce_a: assert property ((s_retire(op_sine_eval) and reduce_q) |->
    run_cnt_q >= `LAT_SIN_MIN + `LAT_ARG_REDUCE)
    else $error("argument reduction time missing");
  store_two_a: assert property ((s_take_nowait and op_dec == op_store_real_double) |=> ##2 op_done)
    else $error("real store not done in two clocks");
  pop_pointer_a: assert property (op_done && op_pops && !op_pushes |=> top_ptr == $past(top_ptr) + `TOP_STEP)
    else $error("pop did not increment pointer");
  push_pointer_a: assert property (op_done && op_pushes |=> top_ptr == $past(top_ptr) - `TOP_STEP)
    else $error("push did not decrement pointer");
  wait_stall_a: assert property (state_q == st_wait && ext_busy |=> !op_done && busy)
    else $error("waiting form ran while unit busy");
  busy_hold_a: assert property (s_take_nowait |=> busy[*2])
    else $error("busy dropped early");
  acc_status_a: assert property (s_retire(op_store_status_accumulator) |->
    run_cnt_q == (wait_q ? `LAT_WSTAT_ACC : `LAT_NSTAT_ACC))
    else $error("accumulator status store latency wrong");
  ext_pop_a: assert property (take && is_db && mem_form && reg_fld == `FLD_111 |=> op_kind == op_store_real_pop_ext)
    else $error("extended real store not decoded as pop");
endmodule

/* test/instr_source.sv */
// processor instruction stream model that feeds opcode pairs to the decoder
`timescale 1ns/1ps
module instr_source (
  input wire logic core_clk,
  input wire logic instr_taken,
  input wire logic illegal_op,
  output logic instr_valid,
  output logic [7:0] opcode_byte,
  output logic [7:0] modrm_byte,
  output logic wait_prefix
);
  // idle stream at time zero
  initial begin
    instr_valid = 1'b0;
    opcode_byte = 8'h00;
    modrm_byte = 8'h00;
    wait_prefix = 1'b0;
  end

  // offer one instruction and hold it until the decoder answers
  task automatic send(input logic [7:0] opc, input logic [7:0] md, input logic wp, output int waited);
    waited = 0;
    instr_valid = 1'b1;
    opcode_byte = opc;
    modrm_byte = md;
    wait_prefix = wp;
    do begin
      @(posedge core_clk);
      #1;
      waited++;
    end while (instr_taken !== 1'b1 && illegal_op !== 1'b1 && waited < 600);
    // released bytes show the inverse, so a stale value never looks valid
    instr_valid = 1'b0;
    opcode_byte = ~opc;
    modrm_byte = ~md;
    wait_prefix = ~wp;
  endtask
endmodule

/* test/tb_fpu_transcendental_store_decode.sv */
// self-checking bench for the transcendental and store decoder
`timescale 1ns/1ps
module tb_fpu_transcendental_store_decode;
  import fpu_decode_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic ext_busy = 1'b0;
  logic fast_case = 1'b1;
  logic arg_out_of_range = 1'b0;
  logic atan_small_ratio = 1'b1;
  logic [2:0] restore_top = 3'h5;
  logic instr_valid, wait_prefix, instr_taken, illegal_op, busy, op_done;
  logic [7:0] opcode_byte, modrm_byte;
  op_kind_t op_kind;
  logic [2:0] dest_entry, top_ptr;
  logic [2:0] exp_top = 3'h0;
  logic rl_pend = 1'b0;
  int err_total = 0;
  int compares = 0;

  fpu_transcendental_store_decode dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .instr_valid(instr_valid), .opcode_byte(opcode_byte), .modrm_byte(modrm_byte), .wait_prefix(wait_prefix),
    .ext_busy(ext_busy), .fast_case(fast_case), .arg_out_of_range(arg_out_of_range),
    .atan_small_ratio(atan_small_ratio), .restore_top(restore_top), .instr_taken(instr_taken),
    .illegal_op(illegal_op), .busy(busy), .op_done(op_done), .op_kind(op_kind), .dest_entry(dest_entry),
    .top_ptr(top_ptr));

  instr_source src_u (.core_clk(core_clk), .instr_taken(instr_taken), .illegal_op(illegal_op),
    .instr_valid(instr_valid), .opcode_byte(opcode_byte), .modrm_byte(modrm_byte), .wait_prefix(wait_prefix));

  // 250 MHz core clock
  always #2 core_clk = ~core_clk;

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // wait for retire, judge latency, busy release and stack move
  task automatic finish_op(input op_kind_t k, input int lat, input int dtop);
    int n;
    n = 0;
    check(32'(op_kind), 32'(k));
    check(32'(busy), 32'h1);
    while (op_done !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    check(32'(n >= lat && n <= lat + 1), 32'h1);
    tick();
    check(32'(busy), 32'h0);
    check(32'(op_done), 32'h0);
    exp_top = rl_pend ? restore_top : exp_top + 3'(dtop);
    rl_pend = 1'b0;
    check(32'(top_ptr), 32'(exp_top));
  endtask

  task automatic run_op(input logic [7:0] opc, input logic [7:0] md, input logic wp, input op_kind_t k,
    input int lat, input int dtop);
    int w;
    src_u.send(opc, md, wp, w);
    check(32'(instr_taken), 32'h1);
    finish_op(k, lat, dtop);
  endtask

  // every encoding of the slice except state restore at the low end of its range
  task automatic t_all_fast();
    fast_case = 1'b1;
    atan_small_ratio = 1'b1;
    run_op(8'hD9, 8'hF3, 1'b0, op_partial_arctangent, 97, 1);
    run_op(8'hD9, 8'hF8, 1'b0, op_partial_remainder, 82, 0);
    run_op(8'hD9, 8'hF5, 1'b0, op_ieee_partial_remainder, 82, 0);
    run_op(8'hD9, 8'hF2, 1'b0, op_partial_tangent, 117, -1);
    run_op(8'hD9, 8'hFC, 1'b0, op_round_to_integral, 10, 0);
    run_op(8'hDD, 8'h31, 1'b1, op_save_unit_state, 57, 0);
    run_op(8'hDD, 8'h31, 1'b0, op_save_unit_state, 55, 0);
    run_op(8'hD9, 8'hFD, 1'b0, op_power_of_two_scale, 7, 0);
    run_op(8'hD9, 8'hFE, 1'b0, op_sine_eval, 76, 0);
    run_op(8'hD9, 8'hFB, 1'b0, op_sine_cosine_eval, 145, -1);
    run_op(8'hD9, 8'hFA, 1'b0, op_square_root_eval, 59, 0);
    run_op(8'hDD, 8'hD3, 1'b0, op_store_real_entry, 2, 0);
    check(32'(dest_entry), 32'h3);
    run_op(8'hDD, 8'h11, 1'b0, op_store_real_double, 2, 0);
    run_op(8'hD9, 8'h11, 1'b0, op_store_real_single, 2, 0);
    run_op(8'hDB, 8'h39, 1'b0, op_store_real_pop_ext, 2, 1);
    run_op(8'hDD, 8'h19, 1'b0, op_store_real_pop_double, 2, 1);
    run_op(8'hD9, 8'h19, 1'b0, op_store_real_pop_single, 2, 1);
    run_op(8'hDF, 8'h31, 1'b0, op_store_bcd_pop, 57, 1);
    run_op(8'hDB, 8'h11, 1'b0, op_store_integer_long, 8, 0);
    run_op(8'hDF, 8'h11, 1'b0, op_store_integer_word, 7, 0);
    run_op(8'hDF, 8'h39, 1'b0, op_store_integer_pop_quad, 10, 1);
    run_op(8'hDB, 8'h19, 1'b0, op_store_integer_pop_long, 8, 1);
    run_op(8'hDF, 8'h19, 1'b0, op_store_integer_pop_word, 7, 1);
    run_op(8'hD9, 8'h39, 1'b1, op_store_control_word, 5, 0);
    run_op(8'hD9, 8'h39, 1'b0, op_store_control_word, 3, 0);
    run_op(8'hD9, 8'h31, 1'b1, op_store_environment, 14, 0);
    run_op(8'hD9, 8'h31, 1'b0, op_store_environment, 12, 0);
    run_op(8'hDD, 8'h39, 1'b1, op_store_status_word, 6, 0);
    run_op(8'hDD, 8'h39, 1'b0, op_store_status_word, 4, 0);
    run_op(8'hDF, 8'hE0, 1'b1, op_store_status_accumulator, 4, 0);
    run_op(8'hDF, 8'hE0, 1'b0, op_store_status_accumulator, 2, 0);
  endtask

  // high end of the ranges and the long arctangent path
  task automatic t_slow();
    fast_case = 1'b0;
    atan_small_ratio = 1'b0;
    run_op(8'hD9, 8'hF3, 1'b0, op_partial_arctangent, 161, 1);
    run_op(8'hD9, 8'hF8, 1'b0, op_partial_remainder, 91, 0);
    run_op(8'hD9, 8'hFC, 1'b0, op_round_to_integral, 20, 0);
    run_op(8'hDD, 8'h31, 1'b0, op_save_unit_state, 65, 0);
    run_op(8'hD9, 8'hFA, 1'b0, op_square_root_eval, 60, 0);
    run_op(8'hDF, 8'h19, 1'b0, op_store_integer_pop_word, 10, 1);
    run_op(8'hD9, 8'h31, 1'b1, op_store_environment, 24, 0);
    fast_case = 1'b1;
  endtask

  // large trig arguments pay the reduction cost
  task automatic t_reduce();
    arg_out_of_range = 1'b1;
    run_op(8'hD9, 8'hF2, 1'b0, op_partial_tangent, 207, -1);
    run_op(8'hD9, 8'hFE, 1'b0, op_sine_eval, 166, 0);
    run_op(8'hD9, 8'hFB, 1'b0, op_sine_cosine_eval, 235, -1);
    arg_out_of_range = 1'b0;
  endtask

  // waiting form stalls on a busy unit, non-waiting form does not
  task automatic t_wait_stall();
    int w;
    logic early;
    early = 1'b0;
    ext_busy = 1'b1;
    run_op(8'hDD, 8'h39, 1'b0, op_store_status_word, 4, 0);
    // waiting form is taken at once, then parks until the unit is idle
    src_u.send(8'hD9, 8'h39, 1'b1, w);
    check(32'(w), 32'h1);
    repeat (20) begin
      tick();
      if (op_done !== 1'b0 || busy !== 1'b1) early = 1'b1;
    end
    check(32'(early), 32'h0);
    ext_busy = 1'b0;
    // count includes the edge that sees the unit idle
    finish_op(op_store_control_word, 5, 0);
  endtask

  // state restore reloads the stack pointer
  task automatic t_restore();
    rl_pend = 1'b1;
    run_op(8'hDD, 8'h21, 1'b0, op_restore_unit_state, 56, 0);
  endtask

  // opcodes outside the slice are flagged and never taken
  task automatic t_illegal();
    int w;
    src_u.send(8'hD8, 8'hC0, 1'b0, w);
    check(32'(illegal_op), 32'h1);
    check(32'(instr_taken), 32'h0);
    tick();
    check(32'(busy), 32'h0);
    check(32'(top_ptr), 32'(exp_top));
  endtask

  // watchdog over the whole run
  initial begin
    #40000;
    err_total++;
    summarize();
  end

  // reset, then the scenarios back to back
  initial begin
    repeat (10) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    check(32'(top_ptr), 32'h0);
    check(32'(busy), 32'h0);
    t_all_fast();
    t_slow();
    t_reduce();
    t_wait_stall();
    t_restore();
    t_illegal();
    summarize();
  end
endmodule
